/* File: rtl/ism_pkg.sv */
package ism_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [2:0] OFS_RELOAD = 3'h0;
    localparam logic [2:0] OFS_TXBUF = 3'h1;
    localparam logic [2:0] OFS_CTRL3 = 3'h2;
    localparam logic [2:0] OFS_STATUS = 3'h3;
    localparam logic [2:0] OFS_MASK = 3'h4;
    localparam logic [2:0] OFS_CTRL = 3'h5;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_START = 0;
    localparam int CTL_SPI = 1;
    localparam int CTL_EN = 2;
    localparam int CTL_BUSY = 3;
    localparam int STS_COLL = 0;
    localparam int STS_START = 1;
    localparam int STS_XFER = 2;
    localparam int C3_ACK_TIME_STATUS = 7;
    localparam int C3_ADDRESS_HOLD_ENABLE = 1;
    localparam int C3_DATA_HOLD_ENABLE = 0;

    // ------------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [2:0] RST_FLAGS = 3'h0;
    localparam int TICK_DIV_DEF = 2;
    localparam logic [4:0] I2C_HALVES = 5'h12;
    localparam logic [4:0] SPI_HALVES = 5'h10;
    localparam logic [4:0] ACK_HALF = 5'h10;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CHECK,
        ST_START1,
        ST_START2,
        ST_RUN
    } ism_state_e;

endpackage

/* File: rtl/ism_master.sv */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps

// Summary of operation
// - Start flags collision when data or clock line already low at start.
// - On start collision abort, set collision flag, return sequencer to idle.
// - Clock low before we drive data low during start is a collision.
// - With data line high, load baud counter from reload and count down.
// - Clock low while data still high in first count means collision.
// - Data low in first count: reload counter, drive data low at once.
// - Data high through first count: drive data low at expiry, reload again.
// - Clock low during the second start count is not a collision.
// - Second count expiry drives clock low, completing the start.
// - Counter reloads from reload register, starts on transmit buffer write.
// - When operation ends counting stops and clock pin holds its level.
// - Counter reloads twice per serial clock period.
// - Serial clock equals system clock over twice TICK_DIV times reload plus one.
// - One baud counter clocks both two-wire and SPI master modes.
// - Control three: read-only ack-time flag plus seven read/write bits, reset 0.
// - Ack-time flag operates only while address or data hold enabled.
module ism_master
    import ism_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sda_in,
    input wire logic scl_in,
    output logic sda_out,
    output logic sda_oe,
    output logic scl_out,
    output logic scl_oe,
    output logic spi_sck,
    output logic spi_sdo,
    output logic irq
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Prescaler is three bits wide
    if (TICK_DIV < 1 || TICK_DIV > 8) begin : g_bad_div
        $error("TICK_DIV must lie in 1..8");
    end

    localparam logic [2:0] PRE_LAST = 3'(TICK_DIV - 1);

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        ism_state_e state;
        logic [2:0] sda_sync;
        logic [2:0] scl_sync;
        logic sda_f;
        logic scl_f;
        logic [7:0] reload;
        logic [7:0] txbuf;
        logic [6:0] c3;
        logic ack_time_status;
        logic [2:0] sts;
        logic [2:0] mask;
        logic spi_mode;
        logic enable;
        logic [7:0] cnt;
        logic [2:0] pre;
        logic [4:0] halves;
        logic [7:0] shreg;
        logic sda_oe;
        logic scl_oe;
        logic sck;
        logic sdo;
        logic irq;
        logic [7:0] rdata;
    } ism_st_s;

    ism_st_s st_ff;
    ism_st_s nxt_st;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        logic counting;
        logic tick;
        logic expired;
        logic wr_ctrl;
        logic wr_txbuf;
        logic start_req;
        logic [2:0] ev;
        logic [2:0] clr;
        logic [4:0] halves_inc;
        logic [4:0] total;
        counting = 1'b0;
        tick = 1'b0;
        expired = 1'b0;
        wr_ctrl = 1'b0;
        wr_txbuf = 1'b0;
        start_req = 1'b0;
        ev = RST_FLAGS;
        clr = RST_FLAGS;
        halves_inc = 5'h00;
        total = 5'h00;
        nxt_st = st_ff;

        // Pin synchronisers; a change counts once stages two and three agree
        nxt_st.sda_sync = {st_ff.sda_sync[1:0], sda_in};
        nxt_st.scl_sync = {st_ff.scl_sync[1:0], scl_in};
        if (st_ff.sda_sync[1] == st_ff.sda_sync[2]) begin
            nxt_st.sda_f = st_ff.sda_sync[2];
        end
        if (st_ff.scl_sync[1] == st_ff.scl_sync[2]) begin
            nxt_st.scl_f = st_ff.scl_sync[2];
        end

        // Prescaled decrement; pre stays at zero while idle to save toggling
        counting = (st_ff.state == ST_START1) || (st_ff.state == ST_START2) ||
                   (st_ff.state == ST_RUN);
        tick = counting && (st_ff.pre == PRE_LAST);
        expired = tick && (st_ff.cnt == RST_BYTE);
        if (!counting || tick) begin
            nxt_st.pre = 3'h0;
        end else begin
            nxt_st.pre = st_ff.pre + 3'h1;
        end
        if (tick && (st_ff.cnt != RST_BYTE)) begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
        end

        // Register writes
        wr_ctrl = wr && (addr == OFS_CTRL);
        wr_txbuf = wr && (addr == OFS_TXBUF);
        start_req = wr_ctrl && wdata[CTL_START] && wdata[CTL_EN] && !wdata[CTL_SPI];
        if (wr && (addr == OFS_RELOAD)) begin
            nxt_st.reload = wdata;
        end
        if (wr_txbuf) begin
            nxt_st.txbuf = wdata;
        end
        if (wr && (addr == OFS_CTRL3)) begin
            nxt_st.c3 = wdata[6:0];
        end
        if (wr && (addr == OFS_MASK)) begin
            nxt_st.mask = wdata[2:0];
        end
        if (wr && (addr == OFS_STATUS)) begin
            clr = wdata[2:0];
        end
        if (wr_ctrl) begin
            nxt_st.spi_mode = wdata[CTL_SPI];
            nxt_st.enable = wdata[CTL_EN];
        end

        total = st_ff.spi_mode ? SPI_HALVES : I2C_HALVES;
        halves_inc = st_ff.halves + 5'h01;

        // Sequencer
        case (st_ff.state)
            ST_IDLE: begin
                if (start_req && (st_ff.state == ST_IDLE)) begin
                    nxt_st.state = ST_CHECK;
                end else if (wr_txbuf && st_ff.enable) begin
                    nxt_st.cnt = st_ff.reload;
                    nxt_st.halves = 5'h00;
                    nxt_st.shreg = wdata;
                    nxt_st.state = ST_RUN;
                    if (st_ff.spi_mode) begin
                        nxt_st.sck = 1'b0;
                        nxt_st.sdo = wdata[7];
                    end
                end
            end
            ST_CHECK: begin
                if (!st_ff.sda_f || !st_ff.scl_f) begin
                    ev[STS_COLL] = 1'b1;
                    nxt_st.sda_oe = 1'b0;
                    nxt_st.scl_oe = 1'b0;
                    nxt_st.state = ST_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.reload;
                    nxt_st.state = ST_START1;
                end
            end
            ST_START1: begin
                if (!st_ff.scl_f && st_ff.sda_f) begin
                    // Another master is driving the clock low
                    ev[STS_COLL] = 1'b1;
                    nxt_st.state = ST_IDLE;
                end else if (!st_ff.sda_f) begin
                    nxt_st.cnt = st_ff.reload;
                    nxt_st.pre = 3'h0;
                    nxt_st.sda_oe = 1'b1;
                    nxt_st.state = ST_START2;
                end else if (expired) begin
                    nxt_st.sda_oe = 1'b1;
                    nxt_st.cnt = st_ff.reload;
                    nxt_st.state = ST_START2;
                end
            end
            ST_START2: begin
                // Clock line is not watched here, a low is legal
                if (expired) begin
                    nxt_st.scl_oe = 1'b1;
                    ev[STS_START] = 1'b1;
                    nxt_st.state = ST_IDLE;
                end
            end
            ST_RUN: begin
                if (expired) begin
                    nxt_st.cnt = st_ff.reload;
                    nxt_st.halves = halves_inc;
                    // Same counter feeds both clock pins
                    if (st_ff.spi_mode) begin
                        nxt_st.sck = !st_ff.sck;
                        if (st_ff.sck) begin
                            nxt_st.shreg = {st_ff.shreg[6:0], 1'b0};
                            nxt_st.sdo = st_ff.shreg[6];
                        end
                    end else begin
                        nxt_st.scl_oe = !st_ff.scl_oe;
                    end
                    if (!st_ff.spi_mode && (halves_inc == ACK_HALF) &&
                        (st_ff.c3[C3_ADDRESS_HOLD_ENABLE] || st_ff.c3[C3_DATA_HOLD_ENABLE])) begin
                        nxt_st.ack_time_status = 1'b1;
                    end
                    // Pins are left as they are when the run ends
                    if (halves_inc == total) begin
                        nxt_st.state = ST_IDLE;
                        nxt_st.ack_time_status = 1'b0;
                        ev[STS_XFER] = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.state = ST_IDLE;
            end
        endcase

        // Hold enables off keep the ack-time flag inactive
        if (!nxt_st.c3[C3_ADDRESS_HOLD_ENABLE] && !nxt_st.c3[C3_DATA_HOLD_ENABLE]) begin
            nxt_st.ack_time_status = 1'b0;
        end

        // Disable aborts anything in progress and releases the bus
        if (wr_ctrl && !wdata[CTL_EN]) begin
            nxt_st.state = ST_IDLE;
            nxt_st.sda_oe = 1'b0;
            nxt_st.scl_oe = 1'b0;
            nxt_st.ack_time_status = 1'b0;
        end

        // Sticky flags; a new event beats a same-cycle clear
        nxt_st.sts = (st_ff.sts & ~clr) | ev;
        nxt_st.irq = |(nxt_st.sts & nxt_st.mask);

        // Read data valid in the cycle after the strobe only
        nxt_st.rdata = RST_BYTE;
        if (rd) begin
            case (addr)
                OFS_RELOAD: nxt_st.rdata = st_ff.reload;
                OFS_TXBUF: nxt_st.rdata = st_ff.txbuf;
                OFS_CTRL3: nxt_st.rdata = {st_ff.ack_time_status, st_ff.c3};
                OFS_STATUS: nxt_st.rdata = {5'h00, st_ff.sts};
                OFS_MASK: nxt_st.rdata = {5'h00, st_ff.mask};
                OFS_CTRL: nxt_st.rdata = {4'h0, st_ff.state != ST_IDLE,
                                          st_ff.enable, st_ff.spi_mode, 1'b0};
                default: nxt_st.rdata = RST_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
            st_ff.sda_sync <= 3'h7;
            st_ff.scl_sync <= 3'h7;
            st_ff.sda_f <= 1'b1;
            st_ff.scl_f <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Open-drain: the pin is only ever pulled low
    assign sda_out = 1'b0;
    assign scl_out = 1'b0;
    assign sda_oe = st_ff.sda_oe;
    assign scl_oe = st_ff.scl_oe;
    assign spi_sck = st_ff.sck;
    assign spi_sdo = st_ff.sdo;
    assign irq = st_ff.irq;
    assign rdata = st_ff.rdata;

endmodule

/* File: dv/ism_checker.sv */
`timescale 1ns/1ps
module ism_checker
    import ism_pkg::*;
#(
    parameter int TICK_DIV = 2
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic spi_sck,
    input wire logic irq
);
    // ----
    // Shadows of written registers and interval counters
    // ----
    logic [7:0] rl_ff;
    logic [7:0] mk_ff;
    logic [6:0] c3_ff;
    logic ph_ff;
    logic tv_ff;
    logic sk_ff;
    logic hold_on;
    int gap_ff;
    int tc_ff;

    assign hold_on = c3_ff[C3_ADDRESS_HOLD_ENABLE] | c3_ff[C3_DATA_HOLD_ENABLE];

    // Start phase is set by a start write and ends at any other control write or clock drive; after a start collision it stays set until the next control write
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rl_ff <= 8'h00;
            mk_ff <= 8'h00;
            c3_ff <= 7'h00;
            ph_ff <= 1'b0;
            tv_ff <= 1'b0;
            sk_ff <= 1'b0;
            gap_ff <= 0;
            tc_ff <= 0;
        end else begin
            if (wr && addr == OFS_RELOAD) rl_ff <= wdata;
            if (wr && addr == OFS_MASK) mk_ff <= wdata;
            if (wr && addr == OFS_CTRL3) c3_ff <= wdata[6:0];
            if (wr && addr == OFS_CTRL) ph_ff <= wdata[CTL_START] & wdata[CTL_EN];
            else if (scl_oe) ph_ff <= 1'b0;
            gap_ff <= (sda_oe && !scl_oe) ? gap_ff + 1 : 0;
            sk_ff <= spi_sck;
            tc_ff <= (spi_sck != sk_ff) ? 1 : tc_ff + 1;
            tv_ff <= wr ? 1'b0 : ((spi_sck != sk_ff) ? 1'b1 : tv_ff);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_rdata_idle;
        rdata != 8'h00 |-> $past(rd);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("data outside read slot");
    property p_c3_rw;
        $past(rd) && $past(addr) == OFS_CTRL3 |-> rdata[6:0] == $past(c3_ff);
    endproperty
    a_c3_rw: assert property (p_c3_rw) else $error("control three readback");
    property p_ack_off;
        $past(rd) && $past(addr) == OFS_CTRL3 && !$past(hold_on) && !$past(hold_on, 2)
            |-> !rdata[C3_ACK_TIME_STATUS];
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("ack time flag active");
    property p_scl_order;
        $rose(scl_oe) && ph_ff |-> sda_oe;
    endproperty
    a_scl_order: assert property (p_scl_order) else $error("clock before data");
    property p_start_gap;
        $rose(scl_oe) && ph_ff |-> gap_ff == TICK_DIV * (rl_ff + 1);
    endproperty
    a_start_gap: assert property (p_start_gap) else $error("second count length");
    property p_start_hold;
        $rose(scl_oe) && ph_ff |=> scl_oe [*4];
    endproperty
    a_start_hold: assert property (p_start_hold) else $error("clock not held");
    property p_sck_half;
        $changed(spi_sck) && tv_ff |-> tc_ff == TICK_DIV * (rl_ff + 1);
    endproperty
    a_sck_half: assert property (p_sck_half) else $error("half period length");
    property p_irq_mask;
        irq |-> (mk_ff | $past(mk_ff)) != 8'h00;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
endmodule

bind ism_master ism_checker #(.TICK_DIV(TICK_DIV)) ism_checker_inst (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .sda_oe(sda_oe), .scl_oe(scl_oe), .spi_sck(spi_sck), .irq(irq)
);

/* File: dv/ism_bus_model.sv */
`timescale 1ns/1ps
module ism_bus_model (
    input wire logic sda_oe,
    input wire logic scl_oe,
    input wire logic hold_sda,
    input wire logic hold_scl,
    output logic sda_line,
    output logic scl_line
);
    // Wired-AND with pull-ups: a released line floats back high
    assign sda_line = !(sda_oe || hold_sda);
    assign scl_line = !(scl_oe || hold_scl);
endmodule

/* File: dv/ism_master_bench.sv */
`timescale 1ns/1ps
module ism_master_bench
    import ism_pkg::*;
;
    logic clk, nrst, wr, rd, sda_in, scl_in, hold_sda, hold_scl;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, d;
    logic sda_oe, scl_oe, spi_sck, spi_sdo, irq;
    logic [3:0] outs;
    int miscompares, checked, mdl[8], r, n;

    assign outs = {irq, spi_sck, scl_oe, sda_oe};
    always #5 clk = ~clk;

    ism_master ism_master_inst (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .sda_in(sda_in), .scl_in(scl_in), .sda_out(), .sda_oe(sda_oe),
        .scl_out(), .scl_oe(scl_oe), .spi_sck(spi_sck), .spi_sdo(spi_sdo), .irq(irq));
    ism_bus_model ism_bus_model_inst (.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda(hold_sda),
        .hold_scl(hold_scl), .sda_line(sda_in), .scl_line(scl_in));

    // ----
    // Shared tasks
    // ----
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Model keeps only the bits that read back as written, except the mask, kept at all eight bits
    task automatic wreg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == OFS_STATUS) mdl[3] = mdl[3] & ~int'(v);
        else if (a < 3'h6) mdl[a] = v & ((a == OFS_CTRL) ? 8'h06 : (a == OFS_CTRL3) ? 8'h7F : 8'hFF);
    endtask
    task automatic rchk(input logic [2:0] a, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(what, rdata, 8'(mdl[a]));
    endtask
    // Bounded wait, sampled mid-cycle so edge updates have landed
    task automatic wait_lv(input int b, input logic v, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (outs[b] !== v && n < lim);
        check("wait", {7'h00, outs[b]}, {7'h00, v});
    endtask
    task automatic complete_run;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        miscompares++;
        complete_run;
    end

    initial begin
        clk = 0; nrst = 0; wr = 0; rd = 0; addr = 0; wdata = 0; hold_sda = 0; hold_scl = 0;
        miscompares = 0; checked = 0;
        foreach (mdl[i]) mdl[i] = 0;
        void'($urandom(36483));
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) rchk(3'(a), "reset value");
        $display("reset test done");
        r = $urandom_range(40, 10);
        wreg(OFS_RELOAD, 8'(r));
        wreg(OFS_CTRL3, (8'($urandom) & 8'hFC) | 8'h80);
        wreg(3'h7, 8'hA5);
        wreg(OFS_MASK, 8'h07);
        for (int a = 0; a < 8; a++) rchk(3'(a), "register");
        $display("register test done");
        wreg(OFS_CTRL, 8'h05);
        wait_lv(1, 1'b1, 8 * (r + 1));
        mdl[3] = 2;
        rchk(OFS_STATUS, "start done");
        check("irq", irq, 8'h01);
        wreg(OFS_STATUS, 8'h02);
        rchk(OFS_STATUS, "start clear");
        // Data low, clock low, then clock pulled inside the first count
        for (int k = 0; k < 3; k++) begin
            wreg(OFS_CTRL, 8'h00);
            hold_sda <= (k == 0);
            hold_scl <= (k == 1);
            repeat (6) @(posedge clk);
            wreg(OFS_CTRL, 8'h05);
            hold_scl <= (k != 0);
            repeat (10) @(posedge clk);
            mdl[3] = 1;
            rchk(OFS_STATUS, "collision");
            check("data drive", sda_oe, 8'h00);
            check("irq", irq, 8'h01);
            @(posedge clk);
            hold_sda <= 1'b0;
            hold_scl <= 1'b0;
            wreg(OFS_STATUS, 8'h01);
        end
        $display("collision test done");
        wreg(OFS_CTRL, 8'h00);
        wreg(OFS_CTRL, 8'h05);
        repeat (2) @(posedge clk);
        hold_sda <= 1'b1;
        wait_lv(0, 1'b1, 2 * r - 4);
        @(posedge clk);
        hold_sda <= 1'b0;
        hold_scl <= 1'b1;
        repeat (4) @(posedge clk);
        hold_scl <= 1'b0;
        wait_lv(1, 1'b1, 4 * (r + 1));
        mdl[3] = 2;
        rchk(OFS_STATUS, "early start");
        wreg(OFS_STATUS, 8'h02);
        $display("early start test done");
        // Serial byte out, most significant bit first
        d = 8'($urandom);
        wreg(OFS_CTRL, 8'h00);
        wreg(OFS_CTRL, 8'h06);
        wreg(OFS_TXBUF, d);
        for (int i = 7; i >= 0; i--) begin
            wait_lv(2, 1'b1, 4 * (r + 1) + 8);
            check("serial bit", spi_sdo, {7'h00, d[i]});
            wait_lv(2, 1'b0, 4 * (r + 1));
        end
        wait_lv(3, 1'b1, 4 * (r + 1));
        mdl[3] = 4;
        rchk(OFS_STATUS, "serial done");
        check("clock rest", spi_sck, 8'h00);
        wreg(OFS_STATUS, 8'h04);
        $display("serial test done");
        wreg(OFS_CTRL, 8'h04);
        wreg(OFS_TXBUF, d);
        for (int i = 0; i < 9; i++) begin
            wait_lv(1, 1'b1, 4 * (r + 1));
            wait_lv(1, 1'b0, 4 * (r + 1));
        end
        wait_lv(3, 1'b1, 4 * (r + 1));
        mdl[3] = 4;
        rchk(OFS_STATUS, "two-wire done");
        $display("two-wire test done");
        complete_run;
    end
endmodule
